// *** verilog/rst_standby_pkg.sv ***
// Constants and carrier types for the reset and standby controller
package rst_standby_pkg;

  // Register indices, one aligned word each
  localparam logic [3:0] ADDR_OPTION  = 4'h0;
  localparam logic [3:0] ADDR_STANDBY = 4'h4;
  localparam logic [3:0] ADDR_STATUS  = 4'h8;
  localparam logic [3:0] ADDR_OSC     = 4'hc;

  // Option word field positions
  localparam int OPT_POR_LSB = 0;
  localparam int OPT_LVR_LSB = 4;
  localparam int OPT_LVR_EN  = 7;
  localparam int OPT_A_LEVEL = 8;
  localparam int OPT_B_LEVEL = 9;

  // Standby command codes
  localparam logic [1:0] CMD_PAUSE = 2'h1;
  localparam logic [1:0] CMD_DEEP  = 2'h2;
  localparam logic [1:0] CMD_XTAL  = 2'h3;

  // Reset values and monitor level counts
  localparam logic [9:0] OPTION_RST = 10'h000;
  localparam logic [2:0] OSC_RST    = 3'h1;
  localparam int         POR_LEVELS = 8;
  localparam int         LVR_LEVELS = 7;

  // Time the internal reset is held after its cause clears
  localparam int RST_HOLD_NS  = 40;
  localparam int CLK_NS       = 4;
  localparam int RST_HOLD_CYC = (RST_HOLD_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [3:0] {
    RUN   = 4'b0001,
    PAUSE = 4'b0010,
    DEEP  = 4'b0100,
    XTAL  = 4'b1000
  } mode_t;

  typedef struct packed {
    logic ceramic;
    logic rc;
    logic crystal;
  } osc_t;

  typedef struct packed {
    logic ext_irq_a;
    logic ext_irq_b;
    logic ext_irq_c;
    logic ext_irq_d;
    logic ext_irq_e;
    logic port0;
    logic base_timer;
    logic other;
  } irq_t;

endpackage : rst_standby_pkg

// *** verilog/reset_and_standby_control.sv ***
// Reset sources, supply monitors and the three standby states
`timescale 1ns/10ps
module reset_and_standby_control
  import rst_standby_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        reset,
  // Pins, analog monitors, watchdog and interrupt inputs
  input  wire logic        reset_pin_n,
  input  wire logic        supply_powered,
  input  wire logic [7:0]  supply_above_por,
  input  wire logic [6:0]  supply_below_lvr,
  input  wire logic        wdt_overflow,
  input  wire irq_t        irq_pending,
  // Register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [31:0] reg_rdata,
  // Core control
  output logic             system_reset,
  output logic             cpu_run,
  output logic             periph_run,
  output logic             base_timer_run,
  output logic             irq_service,
  output osc_t             osc_enable
);

  typedef struct packed {
    logic        meta_pin;
    logic        sync_pin;
    logic [7:0]  meta_por;
    logic [7:0]  sync_por;
    logic [6:0]  meta_lvr;
    logic [6:0]  sync_lvr;
    logic        meta_pwr;
    logic        sync_pwr;
    logic        meta_wdt;
    logic        sync_wdt;
    logic        por_done;
    logic [3:0]  hold_cnt;
    logic        sys_rst;
    mode_t       mode;
    logic [9:0]  option;
    osc_t        osc;
    logic        xtal_selected;
    logic [2:0]  cause;
    logic        cpu_run;
    logic        periph_run;
    logic        bt_run;
    logic        irq_service;
    logic [31:0] rdata;
  } state_t;

  state_t st_r, st_nxt;

  logic [2:0] por_sel;
  logic [2:0] lvr_sel;
  logic       por_low;
  logic       lvr_low;
  logic       any_reset;
  logic       stop_wake;
  logic       lvl_a;
  logic       lvl_b;

  always_comb begin
    st_nxt = st_r;
    // Two stages per pin; only the second stage is read by logic
    st_nxt.meta_pin = reset_pin_n;
    st_nxt.sync_pin = st_r.meta_pin;
    st_nxt.meta_por = supply_above_por;
    st_nxt.sync_por = st_r.meta_por;
    st_nxt.meta_lvr = supply_below_lvr;
    st_nxt.sync_lvr = st_r.meta_lvr;
    st_nxt.meta_pwr = supply_powered;
    st_nxt.sync_pwr = st_r.meta_pwr;
    st_nxt.meta_wdt = wdt_overflow;
    st_nxt.sync_wdt = st_r.meta_wdt;

    por_sel = st_r.option[OPT_POR_LSB +: 3];
    lvr_sel = st_r.option[OPT_LVR_LSB +: 3];
    lvl_a   = st_r.option[OPT_A_LEVEL];
    lvl_b   = st_r.option[OPT_B_LEVEL];

    // Threshold stays active until the supply first passes the chosen level
    por_low = !st_r.por_done && !st_r.sync_por[por_sel];
    // Code seven is not a level; it reads as the top threshold
    lvr_low = st_r.option[OPT_LVR_EN] &&
              st_r.sync_lvr[(lvr_sel == 3'h7) ? 3'h6 : lvr_sel];
    any_reset = por_low || lvr_low || !st_r.sync_pin || st_r.sync_wdt;

    // A slipped power flag only clears once supply is fully gone
    if (!st_r.sync_pwr) begin
      st_nxt.por_done = 1'b0;
    end else if (st_r.sync_por[por_sel]) begin
      st_nxt.por_done = 1'b1;
    end

    stop_wake = (irq_pending.ext_irq_a && lvl_a) || (irq_pending.ext_irq_b && lvl_b) ||
                irq_pending.ext_irq_c || irq_pending.ext_irq_d || irq_pending.ext_irq_e ||
                irq_pending.port0;

    st_nxt.rdata = 32'h0000_0000;
    st_nxt.irq_service = 1'b0;

    if (any_reset) begin
      // Reset wake beats any interrupt wake in the same cycle
      st_nxt.sys_rst  = 1'b1;
      st_nxt.hold_cnt = 4'(RST_HOLD_CYC);
      st_nxt.mode     = RUN;
      st_nxt.osc      = '{ceramic: 1'b0, rc: st_r.osc.rc, crystal: 1'b0};
      st_nxt.xtal_selected = 1'b0;
      st_nxt.cause    = {lvr_low || por_low, st_r.sync_wdt, !st_r.sync_pin};
    end else if (st_r.sys_rst) begin
      if (st_r.hold_cnt == 4'h0) begin
        st_nxt.sys_rst = 1'b0;
        st_nxt.osc.ceramic = 1'b1;
      end else begin
        st_nxt.hold_cnt = st_r.hold_cnt - 4'h1;
      end
    end else begin
      unique case (st_r.mode)
        RUN: begin
          if (reg_write && reg_addr == ADDR_STANDBY) begin
            unique case (reg_wdata[1:0])
              CMD_PAUSE: st_nxt.mode = PAUSE;
              CMD_DEEP: begin
                st_nxt.mode = DEEP;
                st_nxt.osc  = '{ceramic: 1'b0, rc: 1'b0, crystal: 1'b0};
              end
              CMD_XTAL: begin
                // Refused unless the crystal is the selected source
                if (st_r.xtal_selected) begin
                  st_nxt.mode = XTAL;
                  st_nxt.osc.ceramic = 1'b0;
                  st_nxt.osc.rc      = 1'b0;
                end
              end
              default: ;
            endcase
          end
          if (reg_write && reg_addr == ADDR_OSC) begin
            st_nxt.osc = reg_wdata[2:0];
            st_nxt.xtal_selected = reg_wdata[3];
          end
          if (reg_write && reg_addr == ADDR_OPTION) begin
            st_nxt.option = reg_wdata[9:0];
          end
        end
        PAUSE: begin
          if (|irq_pending) begin
            st_nxt.mode = RUN;
            st_nxt.irq_service = 1'b1;
          end
        end
        DEEP: begin
          if (stop_wake) begin
            // Only the ceramic oscillator comes back; software must reselect the others
            st_nxt.mode = RUN;
            st_nxt.osc.ceramic = 1'b1;
            st_nxt.irq_service = 1'b1;
          end
        end
        XTAL: begin
          if (stop_wake || irq_pending.base_timer) begin
            st_nxt.mode = RUN;
            st_nxt.osc.ceramic = 1'b1;
            st_nxt.irq_service = 1'b1;
          end
        end
      endcase
    end

    st_nxt.cpu_run    = !st_nxt.sys_rst && st_nxt.mode == RUN;
    st_nxt.periph_run = !st_nxt.sys_rst && (st_nxt.mode == RUN || st_nxt.mode == PAUSE);
    st_nxt.bt_run     = st_nxt.periph_run || (!st_nxt.sys_rst && st_nxt.mode == XTAL);

    if (reg_read) begin
      unique case (reg_addr)
        ADDR_OPTION:  st_nxt.rdata = {22'h0, st_r.option};
        ADDR_STANDBY: st_nxt.rdata = {28'h0, st_r.mode};
        ADDR_STATUS:  st_nxt.rdata = {28'h0, st_r.cause, st_r.sys_rst};
        ADDR_OSC:     st_nxt.rdata = {28'h0, st_r.xtal_selected, st_r.osc};
        default:      st_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      st_r          <= '0;
      st_r.sync_pin <= 1'b1;
      st_r.meta_pin <= 1'b1;
      st_r.sys_rst  <= 1'b1;
      st_r.hold_cnt <= 4'(RST_HOLD_CYC);
      st_r.mode     <= RUN;
      st_r.option   <= OPTION_RST;
      st_r.osc      <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata      = st_r.rdata;
  assign system_reset   = st_r.sys_rst;
  assign cpu_run        = st_r.cpu_run;
  assign periph_run     = st_r.periph_run;
  assign base_timer_run = st_r.bt_run;
  assign irq_service    = st_r.irq_service;
  assign osc_enable     = st_r.osc;

endmodule : reset_and_standby_control

// *** tb/rst_standby_chk.sv ***
// Assertions on the controller ports
`timescale 1ns/10ps
module rst_standby_chk
  import rst_standby_pkg::*;
(
  // Watched ports
  input wire logic clock,
  input wire logic reset,
  input wire irq_t irq_pending,
  input wire logic system_reset,
  input wire logic cpu_run,
  input wire logic periph_run,
  input wire logic base_timer_run,
  input wire logic irq_service,
  input wire osc_t osc_enable
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (reset);
  property p_svc;
    irq_service |-> cpu_run && $past(irq_pending) != 8'h00;
  endproperty
  a_svc: assert property (p_svc) else $error("service without cause");
  property p_pulse;
    irq_service |=> !irq_service;
  endproperty
  a_pulse: assert property (p_pulse) else $error("service too long");
  property p_rst;
    system_reset |-> !cpu_run && !periph_run && !osc_enable.ceramic && !osc_enable.crystal;
  endproperty
  a_rst: assert property (p_rst) else $error("reset left clocks on");
  property p_pause;
    $fell(cpu_run) && periph_run && !system_reset |-> $stable(osc_enable);
  endproperty
  a_pause: assert property (p_pause) else $error("pause moved clocks");
  property p_wake;
    !cpu_run && periph_run && irq_pending != 8'h00 |=> cpu_run || system_reset;
  endproperty
  a_wake: assert property (p_wake) else $error("pause not left");
  property p_deep;
    $fell(periph_run) && !base_timer_run && !system_reset |-> osc_enable == 3'b000;
  endproperty
  a_deep: assert property (p_deep) else $error("deep left clocks on");
  property p_xtal;
    base_timer_run && !periph_run |-> !osc_enable.ceramic && !osc_enable.rc;
  endproperty
  a_xtal: assert property (p_xtal) else $error("xtal left clocks on");
  property p_keep;
    $fell(periph_run) && base_timer_run |-> $stable(osc_enable.crystal);
  endproperty
  a_keep: assert property (p_keep) else $error("crystal changed");
endmodule : rst_standby_chk
bind reset_and_standby_control rst_standby_chk chk (.clock, .reset, .irq_pending, .system_reset,
  .cpu_run, .periph_run, .base_timer_run, .irq_service, .osc_enable);

// *** tb/standby_env.sv ***
// Pins, supply monitors and interrupt sources around the controller
`timescale 1ns/10ps
module standby_env
  import rst_standby_pkg::*;
(
  // Requests from the bench
  input wire logic  clock,
  input wire logic  pin_low,
  input wire logic  wdt_req,
  input wire irq_t  irq_req,
  // Toward the controller
  output logic       reset_pin_n,
  output logic       supply_powered,
  output logic [7:0] supply_above_por,
  output logic [6:0] supply_below_lvr,
  output logic       wdt_overflow,
  output irq_t       irq_pending
);
  // Supply ramps once, one level a cycle, then never sags
  initial supply_above_por = 8'h00;
  always @(posedge clock) supply_above_por <= {supply_above_por[6:0], 1'b1};
  assign supply_powered = supply_above_por[0];
  assign supply_below_lvr = 7'h00;
  assign reset_pin_n = !pin_low;
  assign wdt_overflow = wdt_req;
  assign irq_pending = irq_req;
endmodule : standby_env

// *** tb/reset_and_standby_control_tb.sv ***
// Self-checking bench for the reset and standby controller
`timescale 1ns/10ps
module reset_and_standby_control_tb
  import rst_standby_pkg::*;
;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic pin_low = 1'b0;
  logic wdt_req = 1'b0;
  irq_t irq_req = 8'h00;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic reset_pin_n, supply_powered, wdt_overflow, system_reset, cpu_run, periph_run;
  logic base_timer_run, irq_service;
  logic [7:0] supply_above_por;
  logic [6:0] supply_below_lvr;
  logic [31:0] reg_rdata;
  irq_t irq_pending;
  osc_t osc_enable;
  int errors = 0;
  int compares = 0;
  int cycles = 0;
  always #2 clock = ~clock;
  standby_env env (.clock, .pin_low, .wdt_req, .irq_req, .reset_pin_n, .supply_powered,
    .supply_above_por, .supply_below_lvr, .wdt_overflow, .irq_pending);
  reset_and_standby_control dut (.clock, .reset, .reset_pin_n, .supply_powered,
    .supply_above_por, .supply_below_lvr, .wdt_overflow, .irq_pending, .reg_addr, .reg_wdata,
    .reg_write, .reg_read, .reg_rdata, .system_reset, .cpu_run, .periph_run, .base_timer_run,
    .irq_service, .osc_enable);
  task automatic chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1) begin
      errors++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    chk(reg_rdata === e, "read");
  endtask : rd
  // Interrupt level for two cycles, judging the wake after the first
  task automatic irq(input irq_t v, input logic w, input string m);
    @(posedge clock);
    irq_req <= v;
    @(posedge clock);
    #1;
    chk(cpu_run === w && irq_service === w, m);
    @(posedge clock);
    irq_req <= 8'h00;
  endtask : irq
  task automatic t_boot();
    repeat (100) if (cpu_run !== 1'b1) begin
      @(posedge clock);
      #1;
    end
    #1;
    chk(osc_enable === 3'b100 && system_reset === 1'b0, "boot");
  endtask : t_boot
  task automatic t_pause();
    wr(ADDR_STANDBY, 32'(CMD_PAUSE));
    chk(cpu_run === 1'b0 && periph_run === 1'b1 && osc_enable === 3'b100, "pause");
    rd(ADDR_STANDBY, 32'h2);
    rd(4'h2, 32'h0);
    irq(8'h01, 1'b1, "pause wake");
  endtask : t_pause
  task automatic t_deep();
    wr(ADDR_STANDBY, 32'(CMD_DEEP));
    chk(cpu_run === 1'b0 && periph_run === 1'b0 && osc_enable === 3'b000, "deep");
    irq(8'h02, 1'b0, "timer woke deep");
    irq(8'h80, 1'b0, "edge woke deep");
    irq(8'h04, 1'b1, "port wake");
    wr(ADDR_OPTION, 32'h100);
    wr(ADDR_STANDBY, 32'(CMD_DEEP));
    irq(8'h80, 1'b1, "level wake");
  endtask : t_deep
  task automatic t_xtal();
    wr(ADDR_STANDBY, 32'(CMD_XTAL));
    chk(cpu_run === 1'b1, "xtal taken");
    wr(ADDR_OSC, 32'hd);
    wr(ADDR_STANDBY, 32'(CMD_XTAL));
    chk(cpu_run === 1'b0 && base_timer_run === 1'b1 && osc_enable === 3'b001, "xtal");
    irq(8'h02, 1'b1, "timer wake");
  endtask : t_xtal
  task automatic t_reset(input logic [1:0] c, input logic w);
    wr(ADDR_STANDBY, 32'(c));
    @(posedge clock);
    pin_low <= !w;
    wdt_req <= w;
    repeat (4) @(posedge clock);
    #1;
    chk(system_reset === 1'b1 && cpu_run === 1'b0, "reset wake");
    @(posedge clock);
    pin_low <= 1'b0;
    wdt_req <= 1'b0;
    t_boot();
    rd(ADDR_STATUS, w ? 32'h4 : 32'h2);
  endtask : t_reset
  task automatic stop_test();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  // Ceiling well above the hundred or so cycles the run needs
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      stop_test();
    end
  end
  initial begin
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    t_boot();
    t_pause();
    t_deep();
    t_xtal();
    t_reset(CMD_PAUSE, 1'b0);
    t_reset(CMD_DEEP, 1'b1);
    stop_test();
  end
endmodule : reset_and_standby_control_tb
